// File: inc/hcd_pkg.sv
/*
 * Package for the three-phase Hall commutation decoder: phase drive codes,
 * PWM timing and reset values.
 * Assumes a single 250 MHz core clock shared by every user of the package.
 */
`default_nettype none

package hcd_pkg;

	// ****************************************
	// Phase drive encoding
	// ****************************************
	typedef enum logic [1:0] {
		HCD_OPEN = 2'h0,
		HCD_HIGH = 2'h1,
		HCD_LOW  = 2'h2
	} hcd_drive_t;

	// ****************************************
	// Timing
	// ****************************************
	localparam int HCD_CLK_MHZ = 250;
	localparam int HCD_PWM_FREQ_KHZ = 10;
	// Cycles in one PWM period, derived from clock and PWM rate
	localparam int HCD_PWM_PERIOD_CYC = (HCD_CLK_MHZ * 1000) / HCD_PWM_FREQ_KHZ;
	localparam int HCD_PWM_CNT_W = 16;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [1:0] HCD_DRIVE_RST = 2'h0;
	localparam logic HCD_EN_RST = 1'b0;
	// Pin synchroniser reset: park input held high so reset never parks
	localparam logic [7:0] HCD_SYNC_RST = 8'h04;

endpackage : hcd_pkg

`default_nettype wire

// File: logic/hcd_decoder.sv
/*
 * Three-phase Hall commutation decoder with inhibit, park lock, fault
 * blanking and fixed-frequency pulse-by-pulse current limiting.
 * Assumes all pin inputs are asynchronous to i_core_clk; analog comparators
 * (current limit, undervoltage, thermal) are done outside and arrive as levels.
 */
// What this block does
// - Forward direction maps Hall code to phase drives
// - Reverse direction maps Hall code to phase drives
// - Valid state: one source, one sink, one open
// - Inhibit high opens all three phases
// - Lock low parks: A high, B open, C low
// - PWM chops all drivers at fixed frequency, except in park
// - Overcurrent turns outputs off rest of cycle, except in park
// - Undervoltage holds all phases off
// - Over-temperature tri-states all phases while present
`timescale 1ns/1ns
`default_nettype none

module hcd_decoder
	import hcd_pkg::*;
#(
	parameter int PWM_PERIOD_CYC = HCD_PWM_PERIOD_CYC
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset,
	// Hall sensors and control pins
	input wire logic [2:0] i_hall_abc,
	input wire logic i_dir_fwd,
	input wire logic i_inhibit,
	input wire logic i_lock_n,
	// Protection comparators
	input wire logic i_over_current,
	input wire logic i_under_voltage,
	input wire logic i_over_temp,
	// PWM demand: drive enabled while ramp counter is below duty
	input wire logic [HCD_PWM_CNT_W-1:0] i_pwm_duty,
	// Phase drives: o_x_src = high side on, o_x_snk = low side on
	output logic o_a_src,
	output logic o_a_snk,
	output logic o_b_src,
	output logic o_b_snk,
	output logic o_c_src,
	output logic o_c_snk,
	// Status
	output logic o_fault,
	output logic o_chop_off
);

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [7:0] sync1_r;
	logic [7:0] sync2_r;
	logic [7:0] pins;
	assign pins = {i_hall_abc, i_dir_fwd, i_inhibit, i_lock_n, i_under_voltage, i_over_temp};

	// Two stages on every pin; first stage feeds only the second
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			sync1_r <= HCD_SYNC_RST;
			sync2_r <= HCD_SYNC_RST;
		end else begin
			sync1_r <= pins;
			sync2_r <= sync1_r;
		end
	end

	logic [2:0] hall;
	logic dir_fwd, inhibit, lock_n, uv, ot;
	assign hall = sync2_r[7:5];
	assign dir_fwd = sync2_r[4];
	assign inhibit = sync2_r[3];
	assign lock_n = sync2_r[2];
	assign uv = sync2_r[1];
	assign ot = sync2_r[0];

	logic oc_s1_r, oc_s2_r;

	// Current comparator synchroniser kept apart so its latch reads stage two only
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			oc_s1_r <= 1'b0;
			oc_s2_r <= 1'b0;
		end else begin
			oc_s1_r <= i_over_current;
			oc_s2_r <= oc_s1_r;
		end
	end

	// ****************************************
	// PWM ramp and pulse-by-pulse latch
	// ****************************************
	logic [HCD_PWM_CNT_W-1:0] pwm_cnt_r;
	logic pwm_wrap;
	logic oc_latch_r;
	assign pwm_wrap = (pwm_cnt_r == HCD_PWM_CNT_W'(PWM_PERIOD_CYC - 1));

	// Free-running fixed-frequency ramp
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			pwm_cnt_r <= '0;
		end else if (pwm_wrap) begin
			pwm_cnt_r <= '0;
		end else begin
			pwm_cnt_r <= pwm_cnt_r + 1'b1;
		end
	end

	// Trip holds to period end; a trip on the wrap cycle still wins
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			oc_latch_r <= HCD_EN_RST;
		end else if (oc_s2_r) begin
			oc_latch_r <= 1'b1;
		end else if (pwm_wrap) begin
			oc_latch_r <= 1'b0;
		end
	end

	logic chop_off;
	// All drivers chopped together, not only the sink side
	assign chop_off = oc_latch_r || oc_s2_r || (pwm_cnt_r >= i_pwm_duty);

	// ****************************************
	// Commutation decode
	// ****************************************
	hcd_drive_t dec_a, dec_b, dec_c;

	// Table decode; unused codes fall to all open
	always_comb begin
		dec_a = HCD_OPEN;
		dec_b = HCD_OPEN;
		dec_c = HCD_OPEN;
		if (dir_fwd) begin
			case (hall)
				3'h4: begin dec_b = HCD_HIGH; dec_c = HCD_LOW; end
				3'h6: begin dec_a = HCD_LOW; dec_b = HCD_HIGH; end
				3'h7: begin dec_a = HCD_LOW; dec_c = HCD_HIGH; end
				3'h3: begin dec_b = HCD_LOW; dec_c = HCD_HIGH; end
				3'h1: begin dec_a = HCD_HIGH; dec_b = HCD_LOW; end
				3'h0: begin dec_a = HCD_HIGH; dec_c = HCD_LOW; end
				default: begin dec_a = HCD_OPEN; end
			endcase
		end else begin
			case (hall)
				3'h7: begin dec_a = HCD_HIGH; dec_c = HCD_LOW; end
				3'h6: begin dec_a = HCD_HIGH; dec_b = HCD_LOW; end
				3'h4: begin dec_b = HCD_LOW; dec_c = HCD_HIGH; end
				3'h0: begin dec_a = HCD_LOW; dec_c = HCD_HIGH; end
				3'h1: begin dec_a = HCD_LOW; dec_b = HCD_HIGH; end
				3'h3: begin dec_b = HCD_HIGH; dec_c = HCD_LOW; end
				default: begin dec_a = HCD_OPEN; end
			endcase
		end
		// Park overrides the Hall decode
		if (!lock_n) begin
			dec_a = HCD_HIGH;
			dec_b = HCD_OPEN;
			dec_c = HCD_LOW;
		end
	end

	// ****************************************
	// Output stage
	// ****************************************
	logic force_off;
	// Inhibit, undervoltage and thermal beat everything; the controller
	// is expected to hold inhibit low while it wants the motor driven
	assign force_off = inhibit || uv || ot;

	logic [5:0] drv_nxt, drv_r;
	always_comb begin
		drv_nxt = {dec_a == HCD_HIGH, dec_a == HCD_LOW,
		           dec_b == HCD_HIGH, dec_b == HCD_LOW,
		           dec_c == HCD_HIGH, dec_c == HCD_LOW};
		// Park is a static hold, so it is not chopped
		if (force_off || (chop_off && lock_n)) begin
			drv_nxt = 6'h00;
		end
	end

	// Registered drives keep outputs glitch-free
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			drv_r <= 6'h00;
		end else begin
			drv_r <= drv_nxt;
		end
	end

	logic fault_r, chop_r;
	// Status flags
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			fault_r <= 1'b0;
			chop_r <= 1'b0;
		end else begin
			fault_r <= uv || ot;
			chop_r <= chop_off;
		end
	end

	assign {o_a_src, o_a_snk, o_b_src, o_b_snk, o_c_src, o_c_snk} = drv_r;
	assign o_fault = fault_r;
	assign o_chop_off = chop_r;

	// ****************************************
	// Checks
	// ****************************************
	chk_inhibit_opens: assert property (@(posedge i_core_clk) disable iff (i_reset)
		$rose(inhibit) |=> (drv_r == 6'h00)) else $error("inhibit did not open phases");
	chk_fault_opens: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(uv || ot) |=> !(o_a_src || o_a_snk || o_b_src || o_b_snk || o_c_src || o_c_snk))
		else $error("fault did not open phases");
	chk_one_src_sink: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(drv_r != 6'h00) |-> ($countones({o_a_src, o_b_src, o_c_src}) == 1
		&& $countones({o_a_snk, o_b_snk, o_c_snk}) == 1)) else $error("bad drive pattern");
	chk_park_state: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(!lock_n && !force_off) |=> (drv_r == 6'h21)) else $error("park state wrong");
	chk_oc_holds: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(oc_s2_r || (oc_latch_r && !pwm_wrap)) |=> oc_latch_r) else $error("limit released early");
	chk_fwd_step: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(hall == 3'h4 && dir_fwd && lock_n && !force_off && !chop_off) |=> (drv_r == 6'h09))
		else $error("forward step wrong");
	chk_rev_step: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(hall == 3'h0 && !dir_fwd && lock_n && !force_off && !chop_off) |=> (drv_r == 6'h12))
		else $error("reverse step wrong");
	chk_bad_code: assert property (@(posedge i_core_clk) disable iff (i_reset)
		((hall == 3'h2 || hall == 3'h5) && lock_n) |=> (drv_r == 6'h00)) else $error("bad code drove");
	chk_chop_all: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(chop_off && lock_n) |=> (drv_r == 6'h00)) else $error("chop left a driver on");

endmodule : hcd_decoder

`default_nettype wire

// File: test/hcd_stage.sv
/*
 * Power stage model: three totem-pole legs seen from their gate commands.
 * Assumes the decoder gates arrive as registered levels.
 */
`timescale 1ns/1ns
`default_nettype none

module hcd_stage
	import hcd_pkg::*;
(
	// Gates {a_src,a_snk,b_src,b_snk,c_src,c_snk}
	input wire logic [5:0] i_gate,
	// Leg view and shoot-through
	output logic [5:0] o_drv,
	output logic o_short
);
	// A leg with both switches on would short the supply
	assign o_drv = i_gate;
	assign o_short = |(i_gate & (i_gate >> 1) & 6'h15);
endmodule : hcd_stage

`default_nettype wire

// File: test/hcd_decoder_tb.sv
/*
 * Self-checking bench for the Hall commutation decoder.
 * Assumes the decoder reacts to pin changes within a few clock edges.
 */
`timescale 1ns/1ns
`default_nettype none

module hcd_decoder_tb;
	import hcd_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	localparam int PER = 50;
	logic i_core_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [2:0] i_hall_abc = 3'h0;
	logic i_dir_fwd = 1'b1;
	logic i_inhibit = 1'b0;
	logic i_lock_n = 1'b1;
	logic i_over_current = 1'b0;
	logic i_under_voltage = 1'b0;
	logic i_over_temp = 1'b0;
	logic [HCD_PWM_CNT_W-1:0] i_pwm_duty = 16'hFFFF;
	logic a_src, a_snk, b_src, b_snk, c_src, c_snk, fault, chop, shorted;
	logic [5:0] drv;
	int n_mismatch = 0;
	int checked = 0;
	int k;
	int n_on;
	// Forward decode by Hall code; reverse reads it at the inverted code
	logic [5:0] fwd [8] = '{6'h21, 6'h24, 6'h00, 6'h06, 6'h09, 6'h00, 6'h18, 6'h12};

	always #2 i_core_clk = ~i_core_clk;

	hcd_decoder #(.PWM_PERIOD_CYC(PER)) dut (.i_core_clk(i_core_clk), .i_reset(i_reset),
		.i_hall_abc(i_hall_abc), .i_dir_fwd(i_dir_fwd), .i_inhibit(i_inhibit), .i_lock_n(i_lock_n),
		.i_over_current(i_over_current), .i_under_voltage(i_under_voltage), .i_over_temp(i_over_temp),
		.i_pwm_duty(i_pwm_duty), .o_a_src(a_src), .o_a_snk(a_snk), .o_b_src(b_src), .o_b_snk(b_snk),
		.o_c_src(c_src), .o_c_snk(c_snk), .o_fault(fault), .o_chop_off(chop));
	hcd_stage stage (.i_gate({a_src, a_snk, b_src, b_snk, c_src, c_snk}), .o_drv(drv), .o_short(shorted));

	// ****************************************
	// Tasks
	// ****************************************
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	// Two sync flops plus the drive register, with margin
	task settle;
		repeat (6) @(negedge i_core_clk);
	endtask : settle

	task test_done;
		if (n_mismatch == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (16) @(negedge i_core_clk);
		i_reset = 1'b0;
		// Every code in both directions, including the two unused codes
		for (k = 0; k < 16; k++) begin
			i_dir_fwd = ~k[3];
			i_hall_abc = k[2:0];
			settle;
			cmp({shorted, 1'b0, drv}, {2'h0, fwd[k[3] ? ~k[2:0] : k[2:0]]});
		end
		// Inhibit beats park, park beats decode and direction
		i_hall_abc = 3'h4;
		i_inhibit = 1'b1;
		i_lock_n = 1'b0;
		settle;
		cmp({2'h0, drv}, 8'h00);
		i_inhibit = 1'b0;
		i_dir_fwd = 1'b0;
		settle;
		cmp({2'h0, drv}, 8'h21);
		i_lock_n = 1'b1;
		i_dir_fwd = 1'b1;
		// Undervoltage then over-temperature, each released again
		for (k = 1; k < 3; k++) begin
			{i_over_temp, i_under_voltage} = k[1:0];
			settle;
			cmp({fault, 1'b0, drv}, 8'h80);
			{i_over_temp, i_under_voltage} = 2'h0;
			settle;
			cmp({fault, 1'b0, drv}, 8'h09);
		end
		// Duty of 20 out of 50: drive on 20 cycles, all legs off 30
		i_pwm_duty = 16'h0014;
		settle;
		n_on = 0;
		k = 0;
		repeat (PER) begin
			@(negedge i_core_clk);
			n_on += (drv === 6'h09);
			k += (drv === 6'h00);
		end
		cmp(8'(n_on), 8'h14);
		cmp(8'(k), 8'h1E);
		// Trip held across a wrap stays off, then recovers within a period plus 8 cycles
		i_pwm_duty = 16'hFFFF;
		i_over_current = 1'b1;
		repeat (PER + 8) @(negedge i_core_clk);
		cmp({chop, 1'b0, drv}, 8'h80);
		i_over_current = 1'b0;
		k = 0;
		while (drv !== 6'h09 && k < PER + 8) begin
			@(negedge i_core_clk);
			k++;
		end
		cmp({2'h0, drv}, 8'h09);
		// Short trip early in a period: all legs stay off to the period end
		i_over_current = 1'b1;
		repeat (2) @(negedge i_core_clk);
		i_over_current = 1'b0;
		n_on = 0;
		repeat (PER - 4) begin
			@(negedge i_core_clk);
			n_on += (drv === 6'h09);
		end
		cmp(8'(n_on), 8'h00);
		test_done;
	end

	// Whole run is a few hundred cycles; this is far beyond it
	initial begin
		#100000;
		n_mismatch++;
		test_done;
	end
endmodule : hcd_decoder_tb

`default_nettype wire
